/* verilog/lvd_ctrl_regs.vh */
// register offsets, field positions, reset values and timing counts of the detector control
`ifndef LVD_CTRL_REGS_VH
`define LVD_CTRL_REGS_VH
`define LVD_OFF_CTRL 4'h0
`define LVD_OFF_STAT 4'h4
`define LVD_OFF_MASK 4'h8
`define LVD_OFF_STATE 4'hC
`define LVD_CTRL_RESET_EN 0
`define LVD_CTRL_FALL_IE 1
`define LVD_CTRL_RISE_IE 2
`define LVD_CTRL_DET_EN 3
`define LVD_CTRL_REF_EN 4
`define LVD_CTRL_INT_SEL 5
`define LVD_STAT_FALL 0
`define LVD_STAT_RISE 1
`define LVD_CTRL_RST_VAL 6'h39
`define LVD_MASK_RST_VAL 2'h0
`define LVD_SETTLE_US 50
`define LVD_CLK_MHZ 100
`define LVD_ARM_CYC 3'h5
`define LVD_SETTLE_CYC (`LVD_SETTLE_US * `LVD_CLK_MHZ)
`endif

/* verilog/lvd_sync.v */
// three-stage synchroniser with agreement filter for one comparator output
`timescale 1ns/10ps
module lvd_sync (
  clk,
  rst_n,
  async_in,
  level_out
);
  input wire clk;
  input wire rst_n;
  input wire async_in;
  output reg level_out;

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule // lvd_sync

/* verilog/lvd_ctrl.v */
// low-voltage detector control, flags, interrupt and reset request
// Functional notes
// - detector on after reset, irq enables off
// - fall below threshold: signal low, fall flag
// - fall flag with enable raises irq
// - rise above: signal high, rise flag if enabled
// - supply below reset threshold enters reset
// - flag clears only by 0 after read 1
`timescale 1ns/10ps
`include "lvd_ctrl_regs.vh"
module lvd_ctrl (
  clk,
  rst_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  fall_below_raw,
  rise_above_raw,
  supply_low_raw,
  voltage_interrupt_signal_n,
  irq_vector_zero,
  low_voltage_reset_req,
  detector_enable,
  reference_enable,
  internal_voltage_select,
  irq
);
  input wire clk;
  input wire rst_n;
  input wire [3:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire fall_below_raw;
  input wire rise_above_raw;
  input wire supply_low_raw;
  output reg voltage_interrupt_signal_n;
  output reg irq_vector_zero;
  output reg low_voltage_reset_req;
  output reg detector_enable;
  output reg reference_enable;
  output reg internal_voltage_select;
  output reg irq;

  wire fall_s;
  wire rise_s;
  wire low_s;
  reg [5:0] ctrl_r;
  reg [1:0] flag_r;
  reg [1:0] mask_r;
  reg [1:0] rd_one_r;
  reg fall_d_r;
  reg rise_d_r;
  reg [2:0] arm_cnt_r;
  reg [1:0] flag_nxt;
  reg [1:0] rd_one_nxt;
  reg [31:0] rdata_nxt;
  wire [2:0] raw_vec;
  wire [2:0] sync_vec;
  wire armed;
  wire active;
  wire fall_ev;
  wire rise_ev;
  wire wr_acc;
  wire rd_cap;
  genvar gi;

  // bit 0 fall, bit 1 rise, bit 2 supply
  assign raw_vec = {supply_low_raw, rise_above_raw, fall_below_raw};
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      lvd_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(raw_vec[gi]),
        .level_out(sync_vec[gi])
      );
    end
  endgenerate
  assign fall_s = sync_vec[0];
  assign rise_s = sync_vec[1];
  assign low_s = sync_vec[2];

  assign active = ctrl_r[`LVD_CTRL_DET_EN] & ctrl_r[`LVD_CTRL_REF_EN];
  // edges ignored until synchronisers hold the real pin level
  assign armed = (arm_cnt_r == `LVD_ARM_CYC);
  assign fall_ev = active & armed & fall_s & ~fall_d_r;
  // rise only while supply stays up
  assign rise_ev = active & armed & rise_s & ~rise_d_r & ~low_s;
  // one wait cycle per access; read data loaded as waitrequest drops
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign rd_cap = avs_read & avs_waitrequest;

  always @* begin
    flag_nxt = flag_r;
    rd_one_nxt = rd_one_r;
    // a read remembers which flags it showed set
    if (rd_cap && avs_address == `LVD_OFF_STAT) begin
      rd_one_nxt = rd_one_r | flag_r;
    end
    // clear needs earlier read of one
    if (wr_acc && avs_address == `LVD_OFF_STAT) begin
      flag_nxt = flag_r & ~(rd_one_r & ~avs_writedata[1:0]);
      rd_one_nxt = 2'h0;
    end
    // fall sets flag, set beats clear
    if (fall_ev) begin
      flag_nxt[`LVD_STAT_FALL] = 1'b1;
    end
    if (rise_ev && ctrl_r[`LVD_CTRL_RISE_IE]) begin
      flag_nxt[`LVD_STAT_RISE] = 1'b1;
    end
  end

  always @* begin
    case (avs_address)
      `LVD_OFF_CTRL: rdata_nxt = {26'h0, ctrl_r};
      `LVD_OFF_STAT: rdata_nxt = {30'h0, flag_r};
      `LVD_OFF_MASK: rdata_nxt = {30'h0, mask_r};
      `LVD_OFF_STATE: rdata_nxt = {28'h0, low_s, rise_s, fall_s, voltage_interrupt_signal_n};
      default: rdata_nxt = 32'h0;
    endcase
  end

  // bus handshake and read data
  always @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (rd_cap) begin
        avs_readdata <= rdata_nxt;
      end
    end
  end

  // control and mask registers
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `LVD_CTRL_RST_VAL;
      mask_r <= `LVD_MASK_RST_VAL;
    end else begin
      if (wr_acc && avs_address == `LVD_OFF_CTRL) begin
        ctrl_r <= avs_writedata[5:0];
      end
      if (wr_acc && avs_address == `LVD_OFF_MASK) begin
        mask_r <= avs_writedata[1:0];
      end
    end
  end

  // flags, read memory and edge history
  always @(posedge clk) begin
    if (!rst_n) begin
      flag_r <= 2'h0;
      rd_one_r <= 2'h0;
      fall_d_r <= 1'b0;
      rise_d_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else begin
      flag_r <= flag_nxt;
      rd_one_r <= rd_one_nxt;
      fall_d_r <= fall_s;
      rise_d_r <= rise_s;
      if (!armed) begin
        arm_cnt_r <= arm_cnt_r + 3'h1;
      end
    end
  end

  // interrupt signal level
  always @(posedge clk) begin
    if (!rst_n) begin
      voltage_interrupt_signal_n <= 1'b1;
    end else begin
      if (fall_ev) begin
        voltage_interrupt_signal_n <= 1'b0;
      end else if (rise_ev) begin
        voltage_interrupt_signal_n <= 1'b1;
      end
    end
  end

  // registered outputs
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_vector_zero <= 1'b0;
      low_voltage_reset_req <= 1'b0;
      detector_enable <= 1'b1;
      reference_enable <= 1'b1;
      internal_voltage_select <= 1'b1;
      irq <= 1'b0;
    end else begin
      irq_vector_zero <= (flag_r[`LVD_STAT_FALL] & ctrl_r[`LVD_CTRL_FALL_IE]) |
                         (flag_r[`LVD_STAT_RISE] & ctrl_r[`LVD_CTRL_RISE_IE]);
      // supply low enters reset only with detector and reference on and reset enable set
      low_voltage_reset_req <= active & ctrl_r[`LVD_CTRL_RESET_EN] & low_s;
      detector_enable <= ctrl_r[`LVD_CTRL_DET_EN];
      reference_enable <= ctrl_r[`LVD_CTRL_REF_EN];
      internal_voltage_select <= ctrl_r[`LVD_CTRL_INT_SEL];
      irq <= |(flag_r & mask_r);
    end
  end
endmodule // lvd_ctrl

/* sim/lvd_ctrl_sva.sv */
// port assertions for the detector control
`timescale 1ns/10ps
module lvd_ctrl_sva (
  input wire clk,
  input wire rst_n,
  input wire fall_below_raw,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire voltage_interrupt_signal_n,
  input wire irq_vector_zero,
  input wire low_voltage_reset_req,
  input wire detector_enable,
  input wire reference_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  property p_ack;
    s_req |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("access not answered in one cycle");
  property p_rst_vals;
    $rose(rst_n) |-> voltage_interrupt_signal_n && detector_enable && !irq_vector_zero;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad state after reset");
  property p_fall_sync;
    $fell(voltage_interrupt_signal_n) |-> $past(fall_below_raw, 3);
  endproperty
  a_fall_sync: assert property (p_fall_sync) else $error("signal fell too soon");
  sequence s_fall_held;
    $rose(fall_below_raw) ##0 (detector_enable && reference_enable) ##1
      (fall_below_raw && detector_enable && reference_enable) [*7];
  endsequence
  property p_fall_sig;
    s_fall_held |-> !voltage_interrupt_signal_n;
  endproperty
  a_fall_sig: assert property (p_fall_sig) else $error("signal not low on fall");
  property p_fall_active;
    $fell(voltage_interrupt_signal_n) |-> detector_enable && reference_enable;
  endproperty
  a_fall_active: assert property (p_fall_active) else $error("signal fell while off");
  property p_rst_req;
    low_voltage_reset_req |-> detector_enable && reference_enable;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request while off");
endmodule // lvd_ctrl_sva

/* sim/lvd_ana_model.sv */
// comparator model: pin and supply levels to raw comparator outputs
`timescale 1ns/10ps
module lvd_ana_model (
  input wire ext_high,
  input wire supply_ok,
  output wire fall_below_raw,
  output wire rise_above_raw,
  output wire supply_low_raw
);
  // outputs lag the analog level, unrelated to the clock
  assign #3 fall_below_raw = !ext_high;
  assign #4 rise_above_raw = ext_high;
  assign #3 supply_low_raw = !supply_ok;
endmodule // lvd_ana_model

/* sim/tb.sv */
// self-checking bench for the detector control
`timescale 1ns/10ps
`include "lvd_ctrl_regs.vh"
module tb;
  reg clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, ext_high = 1, supply_ok = 1;
  reg [3:0] avs_address = 4'h0;
  reg [31:0] avs_writedata = 32'h0, d;
  reg [1:0] mk;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, fall_below_raw, rise_above_raw, supply_low_raw;
  wire voltage_interrupt_signal_n, irq_vector_zero, low_voltage_reset_req;
  wire detector_enable, reference_enable, internal_voltage_select, irq;
  integer mismatches = 0, tests_run = 0, seed;
  always #5 clk = ~clk;
  lvd_ana_model U_ANA (.*);
  lvd_ctrl DUT (.*);
  function irq_exp(input [1:0] st, input [1:0] m);
    irq_exp = |(st & m);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [31:0] v);
    begin
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= v;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
    end
  endtask
  task final_report;
    begin
      $display("tests %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #150000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    seed = $urandom(75940);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    acc(0, `LVD_OFF_CTRL, 32'h0);
    chk(d, {26'h0, `LVD_CTRL_RST_VAL});
    acc(0, 4'h2, 32'h0);
    chk(d, 32'h0);
    acc(1, `LVD_OFF_CTRL, 32'h19);
    repeat (`LVD_SETTLE_CYC) @(posedge clk);
    acc(0, `LVD_OFF_STAT, 32'h0);
    acc(1, `LVD_OFF_STAT, 32'h0);
    acc(1, `LVD_OFF_CTRL, 32'h1F);
    mk = $urandom;
    acc(1, `LVD_OFF_MASK, {30'h0, mk});
    $display("enable sequence done");
    ext_high <= 1'b0;
    repeat (12) @(posedge clk);
    chk(voltage_interrupt_signal_n, 1'b0);
    chk(irq_vector_zero, 1'b1);
    chk(irq, irq_exp(2'h1, mk));
    acc(1, `LVD_OFF_STAT, 32'h0);
    acc(0, `LVD_OFF_STAT, 32'h0);
    chk(d, 32'h1);
    ext_high <= 1'b1;
    repeat (12) @(posedge clk);
    chk(voltage_interrupt_signal_n, 1'b1);
    acc(1, `LVD_OFF_STAT, 32'h0);
    acc(0, `LVD_OFF_STAT, 32'h0);
    chk(d, 32'h2);
    acc(1, `LVD_OFF_STAT, 32'h0);
    acc(0, `LVD_OFF_STAT, 32'h0);
    chk(d, 32'h0);
    $display("flag tests done");
    supply_ok <= 1'b0;
    repeat (12) @(posedge clk);
    chk(low_voltage_reset_req, 1'b1);
    supply_ok <= 1'b1;
    acc(1, `LVD_OFF_CTRL, 32'h18);
    acc(1, `LVD_OFF_CTRL, 32'h20);
    repeat (2) @(posedge clk);
    chk({detector_enable, reference_enable, internal_voltage_select}, 3'h1);
    $display("disable test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    acc(0, `LVD_OFF_CTRL, 32'h0);
    chk(d, {26'h0, `LVD_CTRL_RST_VAL});
    acc(0, `LVD_OFF_STAT, 32'h0);
    chk(d, 32'h0);
    chk(irq_vector_zero, 1'b0);
    $display("reset test done");
    final_report;
  end
endmodule // tb
bind lvd_ctrl lvd_ctrl_sva u_sva (.*);
